// [logic/aier_top.sv]
// interrupt enable, pin routing and sticky status with ahb-lite access
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module aier_top
    import aier_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [7:0] src_flag_i,
    output logic irq_pin_a_o,
    output logic irq_pin_a_oe_b_o,
    output logic irq_pin_b_o,
    output logic irq_pin_b_oe_b_o,
    output logic irq_o
);
    aier_reg_if rif ();

    logic [7:0] en_r;
    logic [7:0] en_nxt;
    logic [7:0] route_r;
    logic [7:0] route_nxt;
    logic [7:0] pin_cfg_r;
    logic [7:0] pin_cfg_nxt;
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [7:0] gated_prev_r;
    logic irq_r;
    logic irq_nxt;
    logic [7:0] gated_w;

    // ****************************************
    // bus slave
    // ****************************************
    aier_ahb_slave u_slave (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hready_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .rif(rif)
    );

    // ****************************************
    // write decode
    // ****************************************
    wire wr_enable_w = rif.wr_stb && (rif.idx == IDX_ENABLE);
    wire wr_route_w = rif.wr_stb && (rif.idx == IDX_ROUTING);
    wire wr_pin_cfg_w = rif.wr_stb && (rif.idx == IDX_PIN_CFG);
    wire wr_status_w = rif.wr_stb && (rif.idx == IDX_STATUS);
    wire wr_mask_w = rif.wr_stb && (rif.idx == IDX_MASK);

    // unused bit positions are masked off
    assign en_nxt = wr_enable_w ? (rif.wdata & SRC_MASK) : en_r;
    assign route_nxt = wr_route_w ? (rif.wdata & SRC_MASK) : route_r;
    assign pin_cfg_nxt = wr_pin_cfg_w ? (rif.wdata & PIN_CFG_MASK) : pin_cfg_r;
    assign mask_nxt = wr_mask_w ? (rif.wdata & SRC_MASK) : mask_r;

    // ****************************************
    // source gating
    // ****************************************
    // flags pass only when enabled
    assign gated_w[SLEEP_WAKE_BIT] = src_flag_i[SLEEP_WAKE_BIT] & en_r[SLEEP_WAKE_BIT];
    assign gated_w[6] = 1'b0;
    assign gated_w[TRANSIENT_BIT] = src_flag_i[TRANSIENT_BIT] & en_r[TRANSIENT_BIT];
    assign gated_w[ORIENTATION_BIT] = src_flag_i[ORIENTATION_BIT] & en_r[ORIENTATION_BIT];
    assign gated_w[PULSE_BIT] = src_flag_i[PULSE_BIT] & en_r[PULSE_BIT];
    assign gated_w[FALL_MOTION_BIT] = src_flag_i[FALL_MOTION_BIT] & en_r[FALL_MOTION_BIT];
    assign gated_w[1] = 1'b0;
    assign gated_w[SAMPLE_READY_BIT] = src_flag_i[SAMPLE_READY_BIT] & en_r[SAMPLE_READY_BIT];

    // ****************************************
    // pin steering
    // ****************************************
    // each enabled source on one pin
    // routing 1 to pin a, 0 to pin b
    wire [7:0] to_a_w = gated_w & route_r;
    wire [7:0] to_b_w = gated_w & ~route_r;
    wire lvl_a_w = |to_a_w;
    wire lvl_b_w = |to_b_w;
    wire pol_w = pin_cfg_r[POLARITY_BIT];
    wire od_w = pin_cfg_r[DRIVE_MODE_BIT];

    aier_pin_drv u_pin_a (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .level_i(lvl_a_w),
        .polarity_i(pol_w),
        .open_drain_i(od_w),
        .pin_o(irq_pin_a_o),
        .pin_oe_b_o(irq_pin_a_oe_b_o)
    );

    aier_pin_drv u_pin_b (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .level_i(lvl_b_w),
        .polarity_i(pol_w),
        .open_drain_i(od_w),
        .pin_o(irq_pin_b_o),
        .pin_oe_b_o(irq_pin_b_oe_b_o)
    );

    // ****************************************
    // sticky status and interrupt line
    // ****************************************
    // rising edge of an enabled source; a level held high sets only once
    wire [7:0] rise_w = gated_w & ~gated_prev_r;
    wire [7:0] clr_w = wr_status_w ? (rif.wdata & SRC_MASK) : REG_RST;
    // set wins over a clear in the same cycle
    assign status_nxt = (status_r & ~clr_w) | rise_w;
    assign irq_nxt = |(status_nxt & mask_nxt);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            en_r <= REG_RST;
            route_r <= REG_RST;
            pin_cfg_r <= REG_RST;
            status_r <= REG_RST;
            mask_r <= REG_RST;
            gated_prev_r <= REG_RST;
            irq_r <= 1'b0;
        end else begin
            en_r <= en_nxt;
            route_r <= route_nxt;
            pin_cfg_r <= pin_cfg_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            gated_prev_r <= gated_w;
            irq_r <= irq_nxt;
        end
    end

    assign irq_o = irq_r;

    // ****************************************
    // read mux
    // ****************************************
    // live enabled sources for the host to poll
    wire [7:0] rd_source_w = (rif.idx == IDX_SOURCE) ? gated_w : REG_RST;
    wire [7:0] rd_pin_cfg_w = (rif.idx == IDX_PIN_CFG) ? pin_cfg_r : REG_RST;
    wire [7:0] rd_en_w = (rif.idx == IDX_ENABLE) ? en_r : REG_RST;
    wire [7:0] rd_route_w = (rif.idx == IDX_ROUTING) ? route_r : REG_RST;
    wire [7:0] rd_status_w = (rif.idx == IDX_STATUS) ? status_r : REG_RST;
    wire [7:0] rd_mask_w = (rif.idx == IDX_MASK) ? mask_r : REG_RST;
    // unmapped indices fall through to zero
    assign rif.rdata = rd_source_w | rd_pin_cfg_w | rd_en_w | rd_route_w
                     | rd_status_w | rd_mask_w;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    wire [7:0] src_blocked_w = src_flag_i & ~en_r & SRC_MASK;

    chk_gate_blocks_src: assert property (
        (src_blocked_w != REG_RST) && (gated_w == REG_RST) && !od_w
        |=> (irq_pin_a_o == !$past(pol_w)) && (irq_pin_b_o == !$past(pol_w)))
        else $error("disabled source reached a pin");

    chk_reset_enable_clear: assert property (
        !$past(rst_b_i) |-> (en_r == REG_RST) && (gated_w == REG_RST))
        else $error("enable bits not clear after reset");

    chk_reset_route_clear: assert property (
        !$past(rst_b_i) |-> (route_r == REG_RST) && (pin_cfg_r == REG_RST))
        else $error("routing or pin config not clear after reset");

    chk_pin_a_level: assert property (
        !od_w |=> irq_pin_a_o == ($past(lvl_a_w) ? $past(pol_w) : !$past(pol_w)))
        else $error("pin a level wrong");

    chk_pin_b_route: assert property (
        !od_w && (gated_w != REG_RST) && (route_r == REG_RST)
        |=> (irq_pin_b_o == $past(pol_w)) && (irq_pin_a_o == !$past(pol_w)))
        else $error("routing 0 did not steer to pin b");

    chk_one_pin_only: assert property (
        $onehot(gated_w) && !od_w
        |=> (irq_pin_a_o == $past(pol_w)) ^ (irq_pin_b_o == $past(pol_w)))
        else $error("enabled source not on exactly one pin");

    chk_open_drain_drive: assert property (
        od_w |=> !irq_pin_a_o && !irq_pin_b_o
        && (irq_pin_a_oe_b_o == ($past(lvl_a_w) ? $past(pol_w) : !$past(pol_w))))
        else $error("open drain pin drove high or released wrongly");

    chk_push_pull_drive: assert property (
        !od_w && (gated_w == REG_RST) |=> !irq_pin_a_oe_b_o && !irq_pin_b_oe_b_o
        && (irq_pin_a_o == !$past(pol_w)))
        else $error("push-pull idle level wrong");

    chk_reserved_zero: assert property (
        wr_enable_w || wr_route_w |=> (en_r[6] == 1'b0) && (en_r[1] == 1'b0)
        && (route_r[6] == 1'b0) && (route_r[1] == 1'b0))
        else $error("reserved bit took a write");

    chk_status_set_wins: assert property (
        wr_status_w && (rise_w != REG_RST) |=> ((status_r & $past(rise_w)) == $past(rise_w)))
        else $error("status set lost under clear");

    chk_irq_follows_mask: assert property (
        ((status_r & mask_r) != REG_RST) && !wr_status_w && !wr_mask_w |=> irq_o)
        else $error("interrupt line not high with unmasked status");

    chk_irq_clears: assert property (
        ((status_r & mask_r) == REG_RST) && (rise_w == REG_RST) && !wr_mask_w |=> !irq_o)
        else $error("interrupt line high with nothing unmasked");

    chk_status_sets: assert property (
        (rise_w != REG_RST) |=> ((status_r & $past(rise_w)) == $past(rise_w)))
        else $error("status bit not set by a rising source");

    chk_reset_pins_idle: assert property (
        !$past(rst_b_i) |-> irq_pin_a_o && irq_pin_b_o && !irq_pin_a_oe_b_o
        && !irq_pin_b_oe_b_o && !irq_o)
        else $error("pins or interrupt line not idle after reset");

    // ****************************************
    // per-source end-to-end checks
    // ****************************************
    // push-pull only; the drive checks cover open drain release on pin a, not on pin b
    wire [7:0] live_en_w = src_flag_i & en_r;

    chk_sleep_wake_pin: assert property (
        live_en_w[SLEEP_WAKE_BIT] && !od_w
        |=> ($past(route_r[SLEEP_WAKE_BIT]) ? irq_pin_a_o : irq_pin_b_o) == $past(pol_w))
        else $error("sleep/wake source missed its pin");

    chk_transient_pin: assert property (
        live_en_w[TRANSIENT_BIT] && !od_w
        |=> ($past(route_r[TRANSIENT_BIT]) ? irq_pin_a_o : irq_pin_b_o) == $past(pol_w))
        else $error("transient source missed its pin");

    chk_orientation_pin: assert property (
        live_en_w[ORIENTATION_BIT] && !od_w
        |=> ($past(route_r[ORIENTATION_BIT]) ? irq_pin_a_o : irq_pin_b_o) == $past(pol_w))
        else $error("orientation source missed its pin");

    chk_pulse_pin: assert property (
        live_en_w[PULSE_BIT] && !od_w
        |=> ($past(route_r[PULSE_BIT]) ? irq_pin_a_o : irq_pin_b_o) == $past(pol_w))
        else $error("pulse source missed its pin");

    chk_fall_motion_pin: assert property (
        live_en_w[FALL_MOTION_BIT] && !od_w
        |=> ($past(route_r[FALL_MOTION_BIT]) ? irq_pin_a_o : irq_pin_b_o) == $past(pol_w))
        else $error("fall/motion source missed its pin");

    chk_sample_ready_pin: assert property (
        live_en_w[SAMPLE_READY_BIT] && !od_w
        |=> ($past(route_r[SAMPLE_READY_BIT]) ? irq_pin_a_o : irq_pin_b_o) == $past(pol_w))
        else $error("sample-ready source missed its pin");

    cov_both_pins: cover property (lvl_a_w && lvl_b_w);
    cov_od_release: cover property (od_w ##1 irq_pin_a_oe_b_o);
    cov_set_and_clear: cover property (wr_status_w && (rise_w != REG_RST));
    cov_od_assert: cover property (od_w && lvl_b_w);
    cov_irq_pulse: cover property (!irq_o ##1 irq_o ##[1:20] !irq_o);
endmodule

// [common/aier_pkg.sv]
// constants shared by the interrupt enable and pin routing block
package aier_pkg;
    // register word indices; byte address is four times the index
    localparam logic [7:0] IDX_SOURCE = 8'h0C;
    localparam logic [7:0] IDX_PIN_CFG = 8'h2C;
    localparam logic [7:0] IDX_ENABLE = 8'h2D;
    localparam logic [7:0] IDX_ROUTING = 8'h2E;
    localparam logic [7:0] IDX_STATUS = 8'h30;
    localparam logic [7:0] IDX_MASK = 8'h31;
    localparam logic [7:0] IDX_NONE = 8'hFF;
    localparam logic [21:0] ADDR_HI_ZERO = 22'h00_0000;
    // source bit positions, shared by enable, routing, source, status, mask
    localparam int SLEEP_WAKE_BIT = 7;
    localparam int TRANSIENT_BIT = 5;
    localparam int ORIENTATION_BIT = 4;
    localparam int PULSE_BIT = 3;
    localparam int FALL_MOTION_BIT = 2;
    localparam int SAMPLE_READY_BIT = 0;
    localparam logic [7:0] SRC_MASK = 8'hBD;
    // pin configuration fields
    localparam int POLARITY_BIT = 1;
    localparam int DRIVE_MODE_BIT = 0;
    localparam logic [7:0] PIN_CFG_MASK = 8'h03;
    // reset values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic PIN_IDLE_RST = 1'b1;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [31:0] HRDATA_RST = 32'h0000_0000;
endpackage

// [common/aier_reg_if.sv]
// register access carrier between bus slave and core
`timescale 1ns/1ps
interface aier_reg_if;
    logic wr_stb;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slv (output wr_stb, output idx, output wdata, input rdata);
    modport core (input wr_stb, input idx, input wdata, output rdata);
endinterface

// [logic/aier_ahb_slave.sv]
// ahb-lite slave: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module aier_ahb_slave
    import aier_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    aier_reg_if.slv rif
);
    logic dp_wr_r;
    logic rd_wait_r;
    logic [7:0] idx_r;
    logic [31:0] hrdata_r;

    // ****************************************
    // address phase decode
    // ****************************************
    // only whole-word transfers are used; hsize is not checked
    wire take_w = hsel_i && htrans_i[1] && hready_i;
    wire in_win_w = (haddr_i[31:10] == ADDR_HI_ZERO);
    wire [7:0] idx_nxt = in_win_w ? haddr_i[9:2] : IDX_NONE;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            dp_wr_r <= 1'b0;
            rd_wait_r <= 1'b0;
            idx_r <= IDX_NONE;
            hrdata_r <= HRDATA_RST;
        end else begin
            dp_wr_r <= take_w && hwrite_i;
            rd_wait_r <= take_w && !hwrite_i;
            if (take_w) begin
                idx_r <= idx_nxt;
            end
            // wait cycle lets a write just before land first
            if (rd_wait_r) begin
                hrdata_r <= {24'h00_0000, rif.rdata};
            end
        end
    end

    assign rif.wr_stb = dp_wr_r;
    assign rif.idx = idx_r;
    assign rif.wdata = hwdata_i[7:0];
    assign hrdata_o = hrdata_r;
    assign hreadyout_o = !rd_wait_r;
    assign hresp_o = HRESP_OKAY;
endmodule

// [logic/aier_pin_drv.sv]
// one interrupt pin: polarity and push-pull / open-drain drive
`timescale 1ns/1ps
module aier_pin_drv
    import aier_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic level_i,
    input wire logic polarity_i,
    input wire logic open_drain_i,
    output logic pin_o,
    output logic pin_oe_b_o
);
    logic pin_r;
    logic oe_b_r;

    wire drive_val_w = polarity_i ? level_i : !level_i;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pin_r <= PIN_IDLE_RST;
            oe_b_r <= 1'b0;
        end else begin
            pin_r <= open_drain_i ? 1'b0 : drive_val_w;
            oe_b_r <= open_drain_i ? drive_val_w : 1'b0;
        end
    end

    assign pin_o = pin_r;
    assign pin_oe_b_o = oe_b_r;
endmodule

// [dv/aier_host_model.sv]
// host side of the two interrupt lines, with pull-ups
`timescale 1ns/1ps
module aier_host_model (
    input wire logic pin_a_i,
    input wire logic pin_a_oe_b_i,
    input wire logic pin_b_i,
    input wire logic pin_b_oe_b_i,
    output logic line_a_o,
    output logic line_b_o
);
    // released line pulls up
    // pull-up, not last value, so a stuck release cannot pass
    assign line_a_o = pin_a_oe_b_i ? 1'b1 : pin_a_i;
    assign line_b_o = pin_b_oe_b_i ? 1'b1 : pin_b_i;
endmodule

// [dv/aier_top_tb.sv]
// self-checking bench for the interrupt enable and routing block
`timescale 1ns/1ps
module aier_top_tb
    import aier_pkg::*;
;
    logic sys_clk, rst_b, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] src_flag, rd_val;
    logic pin_a, pin_a_oe_b, pin_b, pin_b_oe_b, irq, line_a, line_b;
    int error_cnt = 0;
    int total_checks = 0;

    aier_top aier_top_inst (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
        .hresp_o(hresp), .src_flag_i(src_flag), .irq_pin_a_o(pin_a),
        .irq_pin_a_oe_b_o(pin_a_oe_b), .irq_pin_b_o(pin_b),
        .irq_pin_b_oe_b_o(pin_b_oe_b), .irq_o(irq)
    );
    aier_host_model aier_host_model_inst (
        .pin_a_i(pin_a), .pin_a_oe_b_i(pin_a_oe_b), .pin_b_i(pin_b),
        .pin_b_oe_b_i(pin_b_oe_b), .line_a_o(line_a), .line_b_o(line_b)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // bounded wait: the slave sets the pace, the bound of 64 cycles only ends a hang
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) chk("hreadyout", 32'h0000_0000, 32'h0000_0001);
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {ADDR_HI_ZERO, idx, 2'b00};
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        wait_rdy();
        rd_val = hrdata[7:0];
    endtask

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(what, rd_val, exp);
    endtask

    // one register stage from flag to pin
    task automatic flags(input logic [7:0] f);
        @(posedge sys_clk);
        src_flag <= f;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic pins(input logic a, input logic b);
        chk("line_a", line_a, a);
        chk("line_b", line_b, b);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        #1;
        chk("oe_b_a", pin_a_oe_b, 1'b0);
        chk("oe_b_b", pin_b_oe_b, 1'b0);
        pins(1'b1, 1'b1);
        rd_chk("enable", IDX_ENABLE, REG_RST);
        rd_chk("routing", IDX_ROUTING, REG_RST);
        rd_chk("pin_cfg", IDX_PIN_CFG, REG_RST);
        rd_chk("status", IDX_STATUS, REG_RST);
        rd_chk("mask", IDX_MASK, REG_RST);
        $display("test reset done");
    endtask

    task automatic t_gate();
        int pos [6] = '{SLEEP_WAKE_BIT, TRANSIENT_BIT, ORIENTATION_BIT, PULSE_BIT,
                        FALL_MOTION_BIT, SAMPLE_READY_BIT};
        logic [7:0] m;
        foreach (pos[i]) begin
            m = 8'h01 << pos[i];
            bus(1'b1, IDX_ENABLE, ~m & SRC_MASK);
            flags(m);
            pins(1'b1, 1'b1);
            rd_chk("source", IDX_SOURCE, 8'h00);
            bus(1'b1, IDX_ENABLE, m);
            flags(m);
            pins(1'b1, 1'b0);
            // host reads the source register once a pin asserts
            rd_chk("source", IDX_SOURCE, m);
            flags(8'h00);
        end
        $display("test gate done");
    endtask

    task automatic t_route();
        bus(1'b1, IDX_ENABLE, SRC_MASK);
        bus(1'b1, IDX_ROUTING, 8'h05);
        flags(8'h01);
        pins(1'b0, 1'b1);
        flags(8'h05);
        pins(1'b0, 1'b1);
        flags(8'h04);
        pins(1'b0, 1'b1);
        flags(8'h84);
        pins(1'b0, 1'b0);
        flags(8'h80);
        pins(1'b1, 1'b0);
        flags(8'h42);
        pins(1'b1, 1'b1);
        flags(8'h00);
        $display("test route done");
    endtask

    task automatic t_resv();
        bus(1'b1, IDX_ENABLE, 8'hFF);
        rd_chk("enable", IDX_ENABLE, 8'hBD);
        bus(1'b1, IDX_ROUTING, 8'hFF);
        rd_chk("routing", IDX_ROUTING, 8'hBD);
        bus(1'b1, IDX_NONE, 8'hFF);
        rd_chk("unmapped", IDX_NONE, 8'h00);
        chk("hresp", hresp, HRESP_OKAY);
        $display("test reserved done");
    endtask

    // reset in mid-run must clear registers written earlier
    task automatic t_rerst();
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        pins(1'b1, 1'b1);
        rd_chk("enable", IDX_ENABLE, REG_RST);
        rd_chk("routing", IDX_ROUTING, REG_RST);
        $display("test mid-run reset done");
    endtask

    task automatic t_pincfg();
        logic [1:0] cfg;
        bus(1'b1, IDX_ENABLE, 8'h01);
        bus(1'b1, IDX_ROUTING, 8'h00);
        for (int c = 0; c < 4; c++) begin
            cfg = c[1:0];
            bus(1'b1, IDX_PIN_CFG, {6'h00, cfg});
            flags(8'h00);
            pins(~cfg[1], ~cfg[1]);
            flags(8'h01);
            pins(~cfg[1], cfg[1]);
            chk("oe_b_a", pin_a_oe_b, cfg[0] & ~cfg[1]);
        end
        bus(1'b1, IDX_PIN_CFG, 8'h00);
        flags(8'h00);
        $display("test pin config done");
    endtask

    task automatic t_irq();
        bus(1'b1, IDX_ENABLE, 8'h08);
        // earlier tests leave sticky bits behind
        bus(1'b1, IDX_STATUS, SRC_MASK);
        bus(1'b1, IDX_MASK, 8'h08);
        flags(8'h00);
        chk("irq", irq, 1'b0);
        flags(8'h18);
        chk("irq", irq, 1'b1);
        flags(8'h00);
        rd_chk("status", IDX_STATUS, 8'h08);
        chk("irq", irq, 1'b1);
        bus(1'b1, IDX_MASK, 8'h00);
        flags(8'h00);
        chk("irq", irq, 1'b0);
        bus(1'b1, IDX_MASK, 8'h08);
        flags(8'h00);
        chk("irq", irq, 1'b1);
        bus(1'b1, IDX_STATUS, 8'h08);
        flags(8'h00);
        chk("irq", irq, 1'b0);
        rd_chk("status", IDX_STATUS, 8'h00);
        flags(8'h08);
        flags(8'h00);
        // clear and a new rise in the same cycle: the rise wins
        fork
            bus(1'b1, IDX_STATUS, 8'h08);
            begin
                repeat (2) @(posedge sys_clk);
                src_flag <= 8'h08;
            end
        join
        rd_chk("status", IDX_STATUS, 8'h08);
        // a level held high does not set the bit again
        bus(1'b1, IDX_STATUS, 8'h08);
        rd_chk("status", IDX_STATUS, 8'h00);
        chk("irq", irq, 1'b0);
        flags(8'h00);
        $display("test interrupt done");
    endtask

    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        src_flag = 8'h00;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_gate();
        t_route();
        t_resv();
        t_rerst();
        t_pincfg();
        t_irq();
        give_verdict();
    end

    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #100us;
        error_cnt++;
        give_verdict();
    end
endmodule
